/* rtl/vift_source.sv */
// Video source: frame timing generator with parallel and LVDS outputs.
// Assumes: ser_clk is seven times the wanted pixel clock, from a PLL;
// enable and mode come from ref_clk logic and may change mid-frame.
//
// What this block does
// RULE1: Link carries only 24-bit single-pixel unbalanced mapping, no dual pixel.
// RULE2: Link clock must lie between 20 and 110 MHz.
// RULE3: Each data lane carries seven bits per link clock period.
// RULE4: Frames repeat at 58 to 61 Hz for all three resolutions; the small frame, 640 by 302 clocks, runs near 103 Hz at the 20 MHz RULE2 floor.
// RULE5: Vsync stays high at least one line each frame.
// RULE6: Vertical back porch, sync included, is at least two lines.
// RULE7: Vertical front porch is at least one line.
// RULE8: Total vertical blanking is at least fourteen lines.
// RULE9: Hsync stays high at least eight pixel clocks each line.
// RULE10: Hsync rise to data valid rise is at least nine clocks.
// RULE11: Data valid fall to next hsync rise is at least eight clocks.
// RULE12: Line blanking at least 64 clocks, line total at most 8191.
// RULE13: Device captures syncs, data valid and pixels on pixel clock edge.
// RULE14: One pixel per clock while valid; lines counted from vsync.
`timescale 1ns/100ps
`include "vift_regs.svh"
module vift_source (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Serial bit clock, seven per pixel
    input wire logic ser_clk,
    // Control from system logic
    input wire logic enable,
    input wire logic [1:0] mode,
    // Status to system logic
    output logic running,
    output logic frame_pulse,
    output logic [15:0] frame_count,
    // Parallel video port
    output logic par_pix_clk,
    output logic par_hsync,
    output logic par_vsync,
    output logic pixel_data_valid,
    output logic [23:0] parallel_pixel_bus,
    // LVDS link
    output logic link_clock_pair_p,
    output logic link_clock_pair_n,
    output logic [3:0] link_data_p,
    output logic [3:0] link_data_n
);

    ////////////////////////////////////////////////////////////////////
    // Resets for both domains

    logic rst_sys_n;
    logic rst_link_n;

    vift_sync2 #(.WIDTH(1)) u_rst_sys (
        .clk(ref_clk),
        .rst_n(resetn),
        .d(1'b1),
        .q(rst_sys_n)
    );

    vift_sync2 #(.WIDTH(1)) u_rst_link (
        .clk(ser_clk),
        .rst_n(resetn),
        .d(1'b1),
        .q(rst_link_n)
    );

    ////////////////////////////////////////////////////////////////////
    // Control into the link domain

    // Mode is only sampled at frame start, so a skewed pair settles first
    logic [2:0] link_ctl;

    vift_sync2 #(.WIDTH(3)) u_ctl (
        .clk(ser_clk),
        .rst_n(rst_link_n),
        .d({enable, mode}),
        .q(link_ctl)
    );

    ////////////////////////////////////////////////////////////////////
    // Link domain: phase, counters and pixel registers

    vift_pix_if pix ();

    vift_pkg::vift_state_t state;
    vift_pkg::vift_state_t next_state;
    vift_pkg::vift_mode_t cur_mode;
    vift_pkg::vift_mode_t next_mode;
    logic [2:0] phase;
    logic [2:0] next_phase;
    logic [12:0] hcnt;
    logic [12:0] next_hcnt;
    logic [11:0] vcnt;
    logic [11:0] next_vcnt;
    logic [12:0] hact;
    logic [11:0] vact;
    logic hs;
    logic vs;
    logic de;
    logic [23:0] rgb;
    logic next_hs;
    logic next_vs;
    logic next_de;
    logic [23:0] next_rgb;
    logic pclk;
    logic next_pclk;
    logic frame_tgl;
    logic next_frame_tgl;
    logic [7:0] frame_lsb;
    logic [7:0] next_frame_lsb;
    logic line_end;
    logic frame_end;

    always_comb begin
        if (cur_mode == vift_pkg::MODE_SQUARE) begin
            hact = `VIFT_HACT_SQUARE;
            vact = `VIFT_VACT_SQUARE;
        end else if (cur_mode == vift_pkg::MODE_SMALL) begin
            hact = `VIFT_HACT_SMALL;
            vact = `VIFT_VACT_SMALL;
        end else begin
            hact = `VIFT_HACT_WIDE;
            vact = `VIFT_VACT_WIDE;
        end
    end

    // RULE12 line total below 8191
    assign line_end = (hcnt == 13'(`VIFT_HBP + hact + `VIFT_HFP - 13'h0001));
    // RULE8 fourteen blank lines
    assign frame_end = line_end &&
        (vcnt == 12'(`VIFT_VBP + vact + `VIFT_VFP - 12'h001));

    // Code 3 has no resolution of its own, so it repeats the small one
    function automatic vift_pkg::vift_mode_t decode_mode(
            input logic [1:0] code);
        if (code == 2'h3) begin
            decode_mode = vift_pkg::MODE_SMALL;
        end else begin
            decode_mode = vift_pkg::vift_mode_t'(code);
        end
    endfunction : decode_mode

    always_comb begin
        next_state = state;
        next_mode = cur_mode;
        next_hcnt = hcnt;
        next_vcnt = vcnt;
        next_frame_tgl = frame_tgl;
        next_frame_lsb = frame_lsb;
        next_phase = (phase == `VIFT_PH_LAST) ? 3'h0 : phase + 3'h1;
        // Pixel clock high mid-pixel, so data is stable at its rise
        next_pclk = (next_phase >= `VIFT_PH_CLK_HI) &&
            (next_phase < `VIFT_PH_CLK_LO);
        // RULE14 one pixel per clock
        if (phase == `VIFT_PH_LAST) begin
            case (state)
                vift_pkg::ST_IDLE: begin
                    next_hcnt = 13'h0000;
                    next_vcnt = 12'h000;
                    if (link_ctl[2]) begin
                        next_state = vift_pkg::ST_RUN;
                        next_mode = decode_mode(link_ctl[1:0]);
                    end
                end
                vift_pkg::ST_RUN: begin
                    next_hcnt = hcnt + 13'h0001;
                    if (line_end) begin
                        next_hcnt = 13'h0000;
                        next_vcnt = vcnt + 12'h001;
                    end
                    if (frame_end) begin
                        next_vcnt = 12'h000;
                        next_frame_tgl = ~frame_tgl;
                        next_frame_lsb = frame_lsb + 8'h01;
                        next_mode = decode_mode(link_ctl[1:0]);
                        // Stopping only at frame end keeps frames whole
                        if (!link_ctl[2]) begin
                            next_state = vift_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = vift_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Pixel fields computed from the counters of the pixel about to start
    always_comb begin
        next_hs = hs;
        next_vs = vs;
        next_de = de;
        next_rgb = rgb;
        if (phase == `VIFT_PH_LAST) begin
            if (next_state == vift_pkg::ST_RUN) begin
                // RULE9 hsync width
                next_hs = (next_hcnt < `VIFT_HSW);
                // RULE5 vsync width, edges with hsync
                next_vs = (next_vcnt < `VIFT_VSW);
                // RULE10 RULE11 horizontal porches
                next_de = (next_hcnt >= `VIFT_HBP) &&
                    (next_hcnt < 13'(`VIFT_HBP + hact)) &&
                    // RULE6 RULE7 vertical porches
                    (next_vcnt >= `VIFT_VBP) &&
                    (next_vcnt < 12'(`VIFT_VBP + vact));
                next_rgb = next_de ? {next_hcnt[7:0], next_vcnt[7:0],
                    frame_lsb} : 24'h000000;
            end else begin
                next_hs = 1'b0;
                next_vs = 1'b0;
                next_de = 1'b0;
                next_rgb = 24'h000000;
            end
        end
    end

    always_ff @(posedge ser_clk or negedge rst_link_n) begin
        if (!rst_link_n) begin
            state <= vift_pkg::ST_IDLE;
            cur_mode <= vift_pkg::MODE_WIDE;
            phase <= 3'h0;
            hcnt <= 13'h0000;
            vcnt <= 12'h000;
            hs <= 1'b0;
            vs <= 1'b0;
            de <= 1'b0;
            rgb <= 24'h000000;
            pclk <= 1'b0;
            frame_tgl <= 1'b0;
            frame_lsb <= 8'h00;
        end else begin
            state <= next_state;
            cur_mode <= next_mode;
            phase <= next_phase;
            hcnt <= next_hcnt;
            vcnt <= next_vcnt;
            hs <= next_hs;
            vs <= next_vs;
            de <= next_de;
            rgb <= next_rgb;
            pclk <= next_pclk;
            frame_tgl <= next_frame_tgl;
            frame_lsb <= next_frame_lsb;
        end
    end

    // RULE13 parallel port from registers
    assign par_pix_clk = pclk;
    assign par_hsync = hs;
    assign par_vsync = vs;
    assign pixel_data_valid = de;
    assign parallel_pixel_bus = rgb;

    ////////////////////////////////////////////////////////////////////
    // LVDS serializer

    logic [`VIFT_LANES-1:0] lane_p;
    logic [`VIFT_LANES-1:0] lane_n;

    assign pix.phase = phase;
    assign pix.hsync = hs;
    assign pix.vsync = vs;
    assign pix.de = de;
    assign pix.rgb = rgb;

    // RULE2 RULE3 link clock is ser_clk over seven
    vift_lvds_ser u_ser (
        .ser_clk(ser_clk),
        .rst_n(rst_link_n),
        .pix(pix.ser),
        .lane_p(lane_p),
        .lane_n(lane_n)
    );

    assign link_data_p = lane_p[3:0];
    assign link_data_n = lane_n[3:0];
    assign link_clock_pair_p = lane_p[4];
    assign link_clock_pair_n = lane_n[4];

    ////////////////////////////////////////////////////////////////////
    // Status back into the system domain

    logic [1:0] sys_stat;
    logic tgl_seen;
    logic next_tgl_seen;
    logic next_frame_pulse;
    logic [15:0] next_frame_count;
    logic link_running;

    assign link_running = (state == vift_pkg::ST_RUN);

    vift_sync2 #(.WIDTH(2)) u_stat (
        .clk(ref_clk),
        .rst_n(rst_sys_n),
        .d({link_running, frame_tgl}),
        .q(sys_stat)
    );

    // RULE4 frames counted for rate checks
    always_comb begin
        next_tgl_seen = sys_stat[0];
        next_frame_pulse = (sys_stat[0] != tgl_seen);
        next_frame_count = frame_count;
        if (next_frame_pulse) begin
            next_frame_count = frame_count + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            tgl_seen <= 1'b0;
            frame_pulse <= 1'b0;
            frame_count <= 16'h0000;
            running <= 1'b0;
        end else begin
            tgl_seen <= next_tgl_seen;
            frame_pulse <= next_frame_pulse;
            frame_count <= next_frame_count;
            running <= sys_stat[1];
        end
    end

endmodule : vift_source

/* rtl/vift_regs.svh */
// Timing and layout constants of the video source.
// Assumes: included by bare name; definitions only.
`ifndef VIFT_REGS_SVH
`define VIFT_REGS_SVH

// Horizontal line layout, in pixel clocks from the hsync rising edge
`define VIFT_HSW 13'h0010
`define VIFT_HBP 13'h0028
`define VIFT_HFP 13'h0018
// Vertical frame layout, in lines from the vsync leading edge
`define VIFT_VSW 12'h002
`define VIFT_VBP 12'h008
`define VIFT_VFP 12'h006
// Active sizes of the three resolutions
`define VIFT_HACT_WIDE 13'h0480
`define VIFT_VACT_WIDE 12'h240
`define VIFT_HACT_SQUARE 13'h0480
`define VIFT_VACT_SQUARE 12'h480
`define VIFT_HACT_SMALL 13'h0240
`define VIFT_VACT_SMALL 12'h120
// Serial bits per link clock period and phase landmarks
`define VIFT_PH_LAST 3'h6
`define VIFT_PH_LOAD 3'h0
`define VIFT_PH_CLK_HI 3'h3
`define VIFT_PH_CLK_LO 3'h6
// Link clock lane pattern, first bit sent in the MSB
`define VIFT_CLK_PATTERN 7'h63
`define VIFT_LANES 5

`endif

/* rtl/vift_pkg.sv */
// Types shared by the video source modules.
// Assumes: nothing; referenced as vift_pkg::name.
package vift_pkg;

    typedef enum logic [1:0] {
        MODE_WIDE,
        MODE_SQUARE,
        MODE_SMALL
    } vift_mode_t;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } vift_state_t;

endpackage : vift_pkg

/* rtl/vift_pix_if.sv */
// Pixel stream from the timing generator to the link serializer.
// Assumes: both ends on the serial bit clock.
`timescale 1ns/100ps
interface vift_pix_if;
    logic [2:0] phase;
    logic hsync;
    logic vsync;
    logic de;
    logic [23:0] rgb;

    modport gen (output phase, hsync, vsync, de, rgb);
    modport ser (input phase, hsync, vsync, de, rgb);
endinterface : vift_pix_if

/* rtl/vift_sync2.sv */
// Two-flop synchroniser for levels, width set by parameter.
// Assumes: d is stable long enough to be seen; rst_n is asynchronous.
`timescale 1ns/100ps
module vift_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
            q <= '0;
        end else begin
            stage <= d;
            q <= stage;
        end
    end
endmodule : vift_sync2

/* rtl/vift_lvds_ser.sv */
// Seven-to-one serializer for the four data lanes and the clock lane.
// Assumes: phase counts 0..6 on ser_clk; pixel fields stand phase 0..6.
`timescale 1ns/100ps
`include "vift_regs.svh"
module vift_lvds_ser (
    // Serial bit clock and its reset
    input wire logic ser_clk,
    input wire logic rst_n,
    // Pixel stream
    vift_pix_if.ser pix,
    // Link lanes, lane 4 carries the clock
    output logic [`VIFT_LANES-1:0] lane_p,
    output logic [`VIFT_LANES-1:0] lane_n
);
    logic [6:0] shreg [`VIFT_LANES];
    logic [6:0] next_shreg [`VIFT_LANES];
    logic [`VIFT_LANES-1:0] next_lane;

    // RULE1 24-bit unbalanced mapping
    function automatic logic [6:0] lane_word(input logic [2:0] lane,
            input logic hs, input logic vs, input logic de,
            input logic [23:0] c);
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        r = c[23:16];
        g = c[15:8];
        b = c[7:0];
        if (lane == 3'h0) begin
            lane_word = {g[0], r[5:0]};
        end else if (lane == 3'h1) begin
            lane_word = {b[1:0], g[5:1]};
        end else if (lane == 3'h2) begin
            lane_word = {de, vs, hs, b[5:2]};
        end else if (lane == 3'h3) begin
            lane_word = {1'b0, b[7:6], g[7:6], r[7:6]};
        end else begin
            lane_word = `VIFT_CLK_PATTERN;
        end
    endfunction : lane_word

    // RULE3 seven bits per period
    generate
        for (genvar i = 0; i < `VIFT_LANES; i++) begin : g_lane
            always_comb begin
                if (pix.phase == `VIFT_PH_LOAD) begin
                    next_shreg[i] = lane_word(3'(i), pix.hsync, pix.vsync,
                        pix.de, pix.rgb);
                end else begin
                    next_shreg[i] = {shreg[i][5:0], 1'b0};
                end
                next_lane[i] = next_shreg[i][6];
            end

            always_ff @(posedge ser_clk or negedge rst_n) begin
                if (!rst_n) begin
                    shreg[i] <= 7'h00;
                    lane_p[i] <= 1'b0;
                    lane_n[i] <= 1'b1;
                end else begin
                    shreg[i] <= next_shreg[i];
                    lane_p[i] <= next_lane[i];
                    lane_n[i] <= ~next_lane[i];
                end
            end
        end
    endgenerate
endmodule : vift_lvds_ser

/* tb/vift_source_monitor.sv */
// Pin checker for the video source, ser_clk domain only.
// Assumes: bound into vift_source; counts are in ser_clk cycles.
`timescale 1ns/100ps
`include "vift_regs.svh"
module vift_source_monitor (
    // Clock and reset
    input wire logic ser_clk,
    input wire logic resetn,
    // Parallel port
    input wire logic par_pix_clk,
    input wire logic par_hsync,
    input wire logic par_vsync,
    input wire logic pixel_data_valid,
    input wire logic [23:0] parallel_pixel_bus,
    // Link
    input wire logic link_clock_pair_p,
    input wire logic link_clock_pair_n,
    input wire logic [3:0] link_data_p,
    input wire logic [3:0] link_data_n
);
    logic [7:0] age;
    logic [7:0] next_age;
    logic hs_q;
    logic de_q;
    logic [15:0] since_hs;
    logic [15:0] next_since_hs;
    logic [15:0] since_de;
    logic [15:0] next_since_de;

    // Front porch is only meaningful in a line that had data valid
    always_comb begin
        next_age = (age == 8'hff) ? age : age + 8'h1;
        next_since_hs = (since_hs == 16'hffff) ? since_hs : since_hs + 16'h1;
        next_since_de = (since_de == 16'hffff) ? since_de : since_de + 16'h1;
        if (par_hsync && !hs_q) begin
            next_since_hs = 16'h1;
            next_since_de = 16'hffff;
        end
        if (de_q && !pixel_data_valid) begin
            next_since_de = 16'h1;
        end
    end

    always_ff @(posedge ser_clk or negedge resetn) begin
        if (!resetn) begin
            age <= 8'h0;
            hs_q <= 1'b0;
            de_q <= 1'b0;
            since_hs <= 16'h0;
            since_de <= 16'hffff;
        end else begin
            age <= next_age;
            hs_q <= par_hsync;
            de_q <= pixel_data_valid;
            since_hs <= next_since_hs;
            since_de <= next_since_de;
        end
    end

    default clocking mon_cb @(posedge ser_clk);
    endclocking
    default disable iff (!resetn);

    sequence pix_steady;
        $stable(par_hsync) && $stable(pixel_data_valid)
            && $stable(parallel_pixel_bus);
    endsequence

    lane_pair_a: assert property (
        {link_clock_pair_n, link_data_n}
            == ~{link_clock_pair_p, link_data_p})
        else $error("lane pair not complementary");
    clk_lane_a: assert property (
        age == 8'hff |-> link_clock_pair_p == $past(link_clock_pair_p, 7))
        else $error("clock lane period is not seven bits");
    pclk_period_a: assert property (
        age == 8'hff |-> par_pix_clk == $past(par_pix_clk, 7))
        else $error("pixel clock period is not seven bits");
    pix_hold_a: assert property (
        $rose(par_pix_clk) |-> pix_steady [*4])
        else $error("pixel port moved around clock rise");
    hs_width_a: assert property (
        $fell(par_hsync) |-> since_hs == `VIFT_HSW * 7)
        else $error("hsync width wrong");
    back_porch_a: assert property (
        $rose(pixel_data_valid) |-> since_hs == `VIFT_HBP * 7)
        else $error("horizontal back porch wrong");
    front_porch_a: assert property (
        $rose(par_hsync) && since_de != 16'hffff
            |-> since_de == `VIFT_HFP * 7)
        else $error("horizontal front porch wrong");
    line_max_a: assert property (
        $rose(par_hsync) |-> since_hs <= 16'hdff9)
        else $error("line longer than allowed");
    vs_align_a: assert property (
        $rose(par_vsync) |-> $rose(par_hsync))
        else $error("vsync edge off the hsync edge");
    blank_zero_a: assert property (
        !pixel_data_valid |-> parallel_pixel_bus == 24'h0)
        else $error("pixel bus not zero in blanking");
endmodule : vift_source_monitor

/* tb/vift_rx_model.sv */
// Receiving device: captures the parallel port, deserializes the link.
// Assumes: the link is sampled on the transmitter's bit clock.
`timescale 1ns/100ps
module vift_rx_model (
    // Bit clock and reset
    input wire logic ser_clk,
    input wire logic rst_n,
    // Parallel port
    input wire logic pix_clk,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic de,
    input wire logic [23:0] pix,
    // Link lanes, lane 4 is the clock lane
    input wire logic [4:0] lane,
    // Captured pixels as {de, vsync, hsync, rgb}
    output logic par_stb,
    output logic [26:0] par_word,
    output logic lvds_stb,
    output logic [26:0] lvds_word
);
    logic pclk_q;
    logic [6:0] sh [5];
    logic [6:0] w [5];

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            w[i] = {sh[i][5:0], lane[i]};
        end
    end

    always_ff @(posedge ser_clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_q <= 1'b0;
            par_stb <= 1'b0;
            lvds_stb <= 1'b0;
            par_word <= '0;
            lvds_word <= '0;
            for (int i = 0; i < 5; i++) begin
                sh[i] <= 7'h0;
            end
        end else begin
            pclk_q <= pix_clk;
            par_stb <= pix_clk & ~pclk_q;
            if (pix_clk & ~pclk_q) begin
                par_word <= {de, vsync, hsync, pix};
            end
            for (int i = 0; i < 5; i++) begin
                sh[i] <= w[i];
            end
            // seven bits framed by clock lane
            lvds_stb <= (w[4] == 7'h63);
            if (w[4] == 7'h63) begin
                lvds_word <= {w[2][6:4], w[3][1:0], w[0][5:0], w[3][3:2],
                    w[1][4:0], w[0][6], w[3][5:4], w[2][3:0], w[1][6:5]};
            end
        end
    end
endmodule : vift_rx_model

/* tb/tb_vift_source.sv */
// Testbench for the video source: all four modes, line layout, vsync width and vertical back porch.
// Assumes: vift_source, vift_rx_model and the pin checker are compiled.
`timescale 1ns/100ps
`include "vift_regs.svh"
module tb_vift_source;
    logic ref_clk = 1'b0;
    logic ser_clk;
    logic resetn;
    logic enable;
    logic [1:0] mode;
    logic [1:0] run_mode;
    logic running, frame_pulse, par_pix_clk, par_hsync, par_vsync, dv;
    logic clk_p, clk_n;
    logic [15:0] frame_count;
    logic [23:0] pbus;
    logic [3:0] data_p, data_n;
    logic par_stb, lvds_stb, hs, vs, de, hs_p, vs_p, de_p, seen_hs, seen_de;
    logic has_de;
    logic [26:0] par_word, lvds_word, total, blank, hs_w, hfp, act;
    logic [26:0] vline, vsw, lines;
    logic [7:0] r_prev;
    logic [1:0] modes [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
    int fail_count = 0;
    int n_checks = 0;

    always #25 ref_clk = ~ref_clk;
    initial begin
        ser_clk = 1'b0;
        #3.3;
        forever #7.5 ser_clk = ~ser_clk;
    end

    vift_source dut (.ref_clk(ref_clk), .resetn(resetn), .ser_clk(ser_clk),
        .enable(enable), .mode(mode), .running(running),
        .frame_pulse(frame_pulse), .frame_count(frame_count),
        .par_pix_clk(par_pix_clk), .par_hsync(par_hsync),
        .par_vsync(par_vsync), .pixel_data_valid(dv),
        .parallel_pixel_bus(pbus), .link_clock_pair_p(clk_p),
        .link_clock_pair_n(clk_n), .link_data_p(data_p),
        .link_data_n(data_n));
    vift_rx_model rx (.ser_clk(ser_clk), .rst_n(resetn),
        .pix_clk(par_pix_clk), .hsync(par_hsync), .vsync(par_vsync),
        .de(dv), .pix(pbus), .lane({clk_p, data_p}), .par_stb(par_stb),
        .par_word(par_word), .lvds_stb(lvds_stb), .lvds_word(lvds_word));

    ////////////////////////////////////////////////////////////////////////
    task check(input logic [26:0] seen, input logic [26:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task at_least(input logic [26:0] v, input logic [26:0] m);
        check((v >= m) ? m : v, m);
    endtask : at_least

    function automatic logic [26:0] hact(input logic [1:0] m);
        return (m < 2'h2) ? 27'(`VIFT_HACT_WIDE) : 27'(`VIFT_HACT_SMALL);
    endfunction : hact

    task summarize;
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    always @(negedge ser_clk) begin
        if (resetn && lvds_stb) begin
            check(lvds_word, par_word);
        end
    end

    // Layout is measured in pixels as the receiving device sees them
    always @(negedge ser_clk) begin
        if (!resetn) begin
            {hs_p, vs_p, de_p, seen_hs, seen_de} = 5'h0;
            lines = '0;
        end else if (par_stb) begin
            {de, vs, hs} = par_word[26:24];
            if (hs && !hs_p) begin
                if (seen_hs) begin
                    check(total, hact(run_mode) + 27'(`VIFT_HBP + `VIFT_HFP));
                    at_least(blank, 27'h40);
                    if (has_de) at_least(hfp, 27'h8);
                end
                vline = (vs && !vs_p) ? '0 : vline + 27'h1;
                vsw = (vs && !vs_p) ? '0 : vsw;
                vsw = vs ? vsw + 27'h1 : vsw;
                {total, blank, hs_w, hfp, act, has_de} = '0;
                lines = lines + 27'h1;
                seen_hs = 1'b1;
            end
            if (!hs && hs_p) at_least(hs_w, 27'h8);
            if (de && !de_p) begin
                at_least(total, 27'h9);
                if (!seen_de) begin
                    check(vsw, 27'(`VIFT_VSW));
                    at_least(vline, 27'h2);
                    check(vline, 27'(`VIFT_VBP));
                end
                seen_de = 1'b1;
            end
            if (!de && de_p) begin
                check(act, hact(run_mode));
                has_de = 1'b1;
                hfp = '0;
            end
            // Red is the column count: it steps by one and wraps at 8 bits
            if (de && de_p) begin
                check(27'(par_word[23:16]), 27'(8'(r_prev + 8'h1)));
            end
            total = total + 27'h1;
            blank = blank + 27'(!de);
            hfp = hfp + 27'(!de);
            hs_w = hs_w + 27'(hs);
            act = act + 27'(de);
            r_prev = par_word[23:16];
            {hs_p, vs_p, de_p} = {hs, vs, de};
        end
    end

    initial begin
        resetn = 1'b0;
        enable = 1'b0;
        mode = 2'h0;
        void'($urandom(66));
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk);
            resetn = 1'b0;
            enable = 1'b0;
            run_mode = modes[i];
            mode = run_mode;
            repeat (5) @(negedge ref_clk);
            check({10'h0, frame_pulse, frame_count}, 27'h0);
            check({20'h0, running, par_hsync, dv, data_n}, 27'hf);
            resetn = 1'b1;
            repeat (3 + $urandom % 32) @(negedge ref_clk);
            enable = 1'b1;
            for (int k = 0; k < 100 && running !== 1'b1; k++) @(negedge ref_clk);
            check({26'h0, running}, 27'h1);
            if (running !== 1'b1) summarize();
            // A mode change and a stop request mid-frame must both wait
            mode = 2'($urandom);
            enable = 1'b0;
            for (int k = 0; k < 40000 && lines < 27'ha; k++) @(negedge ref_clk);
            if (lines < 27'ha) begin
                fail_count++;
                $display("ERROR %0t: timeout waiting for lines", $time);
                summarize();
            end
            // No frame has finished yet, so the count must not have moved
            check({26'h0, running}, 27'h1);
            check({10'h0, frame_pulse, frame_count}, 27'h0);
        end
        summarize();
    end
endmodule : tb_vift_source

bind vift_source vift_source_monitor mon (.ser_clk(ser_clk),
    .resetn(resetn), .par_pix_clk(par_pix_clk), .par_hsync(par_hsync),
    .par_vsync(par_vsync), .pixel_data_valid(pixel_data_valid),
    .parallel_pixel_bus(parallel_pixel_bus),
    .link_clock_pair_p(link_clock_pair_p),
    .link_clock_pair_n(link_clock_pair_n), .link_data_p(link_data_p),
    .link_data_n(link_data_n));
